// file: epm_board_model.sv
// board-side model of the pads: strap wiring, host drive and pad level resolution
`timescale 1ns/1ps
module epm_board_model
  import epm_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic strap_hi_in,
  input wire logic [EPM_NUM_PINS-1:0] ext_en_in,
  input wire logic [EPM_NUM_PINS-1:0] ext_val_in,
  input wire logic [EPM_NUM_PINS-1:0] pad_out_in,
  input wire logic [EPM_NUM_PINS-1:0] pad_oe_in,
  output logic strap_out,
  output logic [EPM_NUM_PINS-1:0] pad_level_out
);
  logic [EPM_NUM_PINS-1:0] float_ff = '0;

  // strap tied to the io supply for spi, to ground for the card port
  assign strap_out = strap_hi_in;

  // a pad nobody drives wanders every cycle, so no stale level is read
  always_ff @(posedge ref_clk_in)
  begin
    float_ff <= ~float_ff;
  end

  // both drivers on: wired-and; else whoever drives; else the floating level
  always_comb
  begin
    for (int i = 0; i < EPM_NUM_PINS; i++)
    begin
      if (pad_oe_in[i] && ext_en_in[i])
        pad_level_out[i] = pad_out_in[i] & ext_val_in[i];
      else if (pad_oe_in[i])
        pad_level_out[i] = pad_out_in[i];
      else if (ext_en_in[i])
        pad_level_out[i] = ext_val_in[i];
      else
        pad_level_out[i] = float_ff[i];
    end
  end
endmodule

// file: epm_pin_mux.sv
// pin multiplexer between board pads and internal peripheral functions
`timescale 1ns/1ps
module epm_pin_mux
  import epm_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [EPM_NUM_PINS-1:0] pad_in_in,
  input wire logic host_cfg_strap_in,
  output logic [EPM_NUM_PINS-1:0] pad_out_out,
  output logic [EPM_NUM_PINS-1:0] pad_oe_out,
  input wire logic sel_wr_in,
  input wire logic [EPM_IDX_W-1:0] sel_idx_in,
  input wire logic [EPM_SEL_W-1:0] sel_val_in,
  input wire logic [EPM_IDX_W-1:0] sel_rd_idx_in,
  output logic [EPM_SEL_W-1:0] sel_rd_val_out,
  output logic host_spi_out,
  output logic host_ready_out,
  input wire logic [EPM_GPIO_W-1:0] gpio_out_in,
  input wire logic [EPM_GPIO_W-1:0] gpio_oe_in,
  output logic [EPM_GPIO_W-1:0] gpio_in_out,
  output logic host_wake_input_out,
  input wire logic interrupt_request_n_in,
  input wire logic uart_txd_in,
  output logic uart_rxd_out,
  input wire logic bus_master_clock_drive_in,
  output logic bus_master_clock_line_out,
  input wire logic bus_master_data_drive_in,
  output logic bus_master_data_line_out,
  input wire logic bus_slave_clock_drive_in,
  output logic bus_slave_clock_line_out,
  input wire logic bus_slave_data_drive_in,
  output logic bus_slave_data_line_out,
  input wire logic [EPM_COEX_W-1:0] coexistence_signal_out_in,
  input wire logic [EPM_COEX_W-1:0] coexistence_signal_oe_in,
  output logic [EPM_COEX_W-1:0] coexistence_signal_line_out,
  input wire logic [3:0] card_data_out_in,
  input wire logic [3:0] card_data_oe_in,
  output logic [3:0] card_data_line_out,
  input wire logic card_command_out_in,
  input wire logic card_command_oe_in,
  output logic card_command_line_out,
  output logic card_clock_input_out,
  output logic slow_clock_out,
  input wire logic spi_miso_in,
  input wire logic spi_miso_oe_in,
  output logic spi_mosi_out,
  output logic chip_select_n_out,
  output logic spi_sck_out
);

  localparam int IN_W = 42;

  // push-pull and open-drain drive pairs {out, oe}
  function automatic logic [1:0] pp(input logic v);
    pp = {v, 1'b1};
  endfunction

  function automatic logic [1:0] od(input logic d);
    od = {1'b0, d};
  endfunction

  // first hit of a fixed-priority list, bit 0 highest, else idle level
  function automatic logic pick(input logic [2:0] hit, input logic [2:0] v,
                                input logic idle);
    pick = hit[0] ? v[0] : hit[1] ? v[1] : hit[2] ? v[2] : idle;
  endfunction

  logic [EPM_NUM_PINS-1:0][EPM_SEL_W-1:0] sel_ff;
  logic [EPM_NUM_PINS-1:0] pad_out_ff;
  logic [EPM_NUM_PINS-1:0] pad_oe_ff;
  logic [EPM_SEL_W-1:0] sel_rd_ff;
  logic [IN_W-1:0] in_ff;
  logic host_spi_ff;
  epm_strap_e strap_ff;
  logic first_ff;

  // ----------------------------------------------------------------
  // pad and strap synchronisers
  // ----------------------------------------------------------------
  logic [EPM_NUM_PINS:0] sync_w;
  logic [EPM_NUM_PINS-1:0] ps;
  logic strap_s;

  epm_sync #(.WIDTH(EPM_NUM_PINS + 1)) u_sync (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .async_in({host_cfg_strap_in, pad_in_in}),
    .sync_out(sync_w)
  );

  assign ps = sync_w[EPM_NUM_PINS-1:0];
  assign strap_s = sync_w[EPM_NUM_PINS];

  // ----------------------------------------------------------------
  // select storage
  // ----------------------------------------------------------------
  wire sel_ok = sel_wr_in && (sel_idx_in < EPM_IDX_W'(EPM_NUM_PINS))
                && (sel_val_in <= EPM_SEL_MAX);
  wire rd_ok = sel_rd_idx_in < EPM_IDX_W'(EPM_NUM_PINS);

  // one write port, out-of-range index or value ignored
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      sel_ff <= '0;
    else if (sel_ok)
      sel_ff[sel_idx_in] <= sel_val_in;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      sel_rd_ff <= EPM_SEL_RESET;
    else
      sel_rd_ff <= rd_ok ? sel_ff[sel_rd_idx_in] : EPM_SEL_RESET;
  end

  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  epm_strap_e nxt_strap;
  assign nxt_strap = (strap_ff == EPM_ST_FILL1) ? EPM_ST_FILL2 :
                     (strap_ff == EPM_ST_FILL2) ? EPM_ST_SAMPLE : EPM_ST_HELD;

  // strap is taken once, when the synchroniser has filled
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      strap_ff <= EPM_ST_FILL1;
      host_spi_ff <= 1'b0;
      first_ff <= 1'b1;
    end
    else
    begin
      strap_ff <= nxt_strap;
      first_ff <= 1'b0;
      if (strap_ff == EPM_ST_SAMPLE)
        host_spi_ff <= (strap_s == EPM_STRAP_SPI);
    end
  end

  wire host_ready = (strap_ff == EPM_ST_HELD);
  wire hs = host_ready && host_spi_ff;
  wire hc = host_ready && !host_spi_ff;

  // ----------------------------------------------------------------
  // per-pin select decode
  // ----------------------------------------------------------------
  logic [EPM_NUM_PINS-1:0] g, p, a, u, m, c;

  for (genvar i = 0; i < EPM_NUM_PINS; i++)
  begin : g_dec
    assign g[i] = sel_ff[i] == EPM_SEL_GPIO;
    assign p[i] = sel_ff[i] == EPM_SEL_PRI;
    assign a[i] = sel_ff[i] == EPM_SEL_ALT;
    assign u[i] = sel_ff[i] == EPM_SEL_UART;
    assign m[i] = sel_ff[i] == EPM_SEL_MST;
    assign c[i] = sel_ff[i] == EPM_SEL_COEX;
  end

  // ----------------------------------------------------------------
  // pad drive, unassigned selects fall through to off
  // ----------------------------------------------------------------
  logic [EPM_NUM_PINS-1:0][1:0] drv;
  wire [1:0] off = 2'b00;
  wire miso_en = hs && !ps[PIN_DAT1] && spi_miso_oe_in;

  assign drv[PIN_WAKE] = g[PIN_WAKE] ? {gpio_out_in[0], gpio_oe_in[0]} :
    u[PIN_WAKE] ? pp(uart_txd_in) : m[PIN_WAKE] ? od(bus_master_clock_drive_in) :
    c[PIN_WAKE] ? {coexistence_signal_out_in[0], coexistence_signal_oe_in[0]} :
    off;
  assign drv[PIN_IRQ] = g[PIN_IRQ] ? {gpio_out_in[2], gpio_oe_in[2]} :
    p[PIN_IRQ] ? pp(interrupt_request_n_in) :
    c[PIN_IRQ] ? {coexistence_signal_out_in[1], coexistence_signal_oe_in[1]} :
    off;
  assign drv[PIN_DAT3] = g[PIN_DAT3] ? {gpio_out_in[7], gpio_oe_in[7]} :
    p[PIN_DAT3] ? {card_data_out_in[3], card_data_oe_in[3]} :
    u[PIN_DAT3] ? pp(uart_txd_in) :
    c[PIN_DAT3] ? {coexistence_signal_out_in[2], coexistence_signal_oe_in[2]} :
    off;
  // shared host pins follow the strap, never the select
  assign drv[PIN_DAT2] = hc ? {card_data_out_in[2], card_data_oe_in[2]} :
    off;
  assign drv[PIN_DAT1] = hc ? {card_data_out_in[1], card_data_oe_in[1]} :
    off;
  assign drv[PIN_DAT0] = hc ? {card_data_out_in[0], card_data_oe_in[0]} :
    {spi_miso_in, miso_en};
  assign drv[PIN_CMD] = hc ? {card_command_out_in, card_command_oe_in} :
    off;
  assign drv[PIN_CCLK] = g[PIN_CCLK] ? {gpio_out_in[8], gpio_oe_in[8]} :
    c[PIN_CCLK] ? {coexistence_signal_out_in[3], coexistence_signal_oe_in[3]} :
    off;
  assign drv[PIN_SCLK] = g[PIN_SCLK] ? {gpio_out_in[1], gpio_oe_in[1]} :
    m[PIN_SCLK] ? od(bus_master_data_drive_in) :
    c[PIN_SCLK] ? {coexistence_signal_out_in[4], coexistence_signal_oe_in[4]} :
    off;
  assign drv[PIN_G15] = g[PIN_G15] ? {gpio_out_in[15], gpio_oe_in[15]} : off;
  assign drv[PIN_G16] = g[PIN_G16] ? {gpio_out_in[16], gpio_oe_in[16]} :
    a[PIN_G16] ? od(bus_master_clock_drive_in) : off;
  assign drv[PIN_G18] = g[PIN_G18] ? {gpio_out_in[18], gpio_oe_in[18]} : off;
  assign drv[PIN_TWC] = p[PIN_TWC] ? od(bus_slave_clock_drive_in) :
    m[PIN_TWC] ? od(bus_master_clock_drive_in) :
    c[PIN_TWC] ? {coexistence_signal_out_in[5], coexistence_signal_oe_in[5]} :
    off;
  assign drv[PIN_TWD] = p[PIN_TWD] ? od(bus_slave_data_drive_in) :
    m[PIN_TWD] ? od(bus_master_data_drive_in) :
    c[PIN_TWD] ? {coexistence_signal_out_in[6], coexistence_signal_oe_in[6]} :
    off;

  // registered pad drivers
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pad_out_ff <= '0;
      pad_oe_ff <= '0;
    end
    else
    begin
      for (int i = 0; i < EPM_NUM_PINS; i++)
      begin
        pad_out_ff[i] <= drv[i][1];
        pad_oe_ff[i] <= drv[i][0];
      end
    end
  end

  // ----------------------------------------------------------------
  // peripheral inputs, each gated by its select or by the host strap, idle when unselected
  // ----------------------------------------------------------------
  wire [EPM_GPIO_W-1:0] gpio_hit = {g[PIN_G18] & ps[PIN_G18], 1'b0,
    g[PIN_G16] & ps[PIN_G16], g[PIN_G15] & ps[PIN_G15], 6'h00,
    g[PIN_CCLK] & ps[PIN_CCLK], g[PIN_DAT3] & ps[PIN_DAT3], 4'h0,
    g[PIN_IRQ] & ps[PIN_IRQ], g[PIN_SCLK] & ps[PIN_SCLK],
    g[PIN_WAKE] & ps[PIN_WAKE]};
  wire wake_hit = p[PIN_WAKE] & ps[PIN_WAKE];
  wire rxd_hit = pick({u[PIN_SCLK], u[PIN_CCLK], u[PIN_IRQ]},
    {ps[PIN_SCLK], ps[PIN_CCLK], ps[PIN_IRQ]}, 1'b1);
  wire mclk_hit = pick({a[PIN_G16], m[PIN_TWC], m[PIN_WAKE]},
    {ps[PIN_G16], ps[PIN_TWC], ps[PIN_WAKE]}, 1'b1);
  wire mdat_hit = pick({1'b0, m[PIN_TWD], m[PIN_SCLK]},
    {1'b0, ps[PIN_TWD], ps[PIN_SCLK]}, 1'b1);
  wire slow_hit = pick({1'b0, u[PIN_TWC], p[PIN_SCLK]},
    {1'b0, ps[PIN_TWC], ps[PIN_SCLK]}, 1'b0);
  wire sclk_hit = p[PIN_TWC] ? ps[PIN_TWC] : 1'b1;
  wire sdat_hit = p[PIN_TWD] ? ps[PIN_TWD] : 1'b1;
  wire [EPM_COEX_W-1:0] coex_hit = {c[PIN_TWD] & ps[PIN_TWD],
    c[PIN_TWC] & ps[PIN_TWC], c[PIN_SCLK] & ps[PIN_SCLK],
    c[PIN_CCLK] & ps[PIN_CCLK], c[PIN_DAT3] & ps[PIN_DAT3],
    c[PIN_IRQ] & ps[PIN_IRQ], c[PIN_WAKE] & ps[PIN_WAKE]};
  wire [3:0] card_hit = {p[PIN_DAT3] ? ps[PIN_DAT3] : 1'b1,
    hc ? ps[PIN_DAT2] : 1'b1, hc ? ps[PIN_DAT1] : 1'b1,
    hc ? ps[PIN_DAT0] : 1'b1};
  wire cmd_hit = hc ? ps[PIN_CMD] : 1'b1;
  wire cclk_hit = p[PIN_CCLK] & ps[PIN_CCLK];
  wire mosi_hit = hs & ps[PIN_DAT2];
  wire ssel_hit = hs ? ps[PIN_DAT1] : 1'b1;
  wire sck_hit = hs & ps[PIN_CMD];

  wire [IN_W-1:0] nxt_in = {gpio_hit, wake_hit, rxd_hit, mclk_hit, mdat_hit,
    sclk_hit, sdat_hit, coex_hit, card_hit, cmd_hit, cclk_hit, slow_hit,
    mosi_hit, ssel_hit, sck_hit};
  localparam logic [IN_W-1:0] IN_IDLE = {19'h0, 6'h1F, 7'h00, 4'hF, 6'h22};

  // registered peripheral inputs, idle levels during reset
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      in_ff <= IN_IDLE;
    else
      in_ff <= nxt_in;
  end

  assign {gpio_in_out, host_wake_input_out, uart_rxd_out,
    bus_master_clock_line_out, bus_master_data_line_out,
    bus_slave_clock_line_out, bus_slave_data_line_out,
    coexistence_signal_line_out, card_data_line_out, card_command_line_out,
    card_clock_input_out, slow_clock_out, spi_mosi_out, chip_select_n_out,
    spi_sck_out} = in_ff;
  assign pad_out_out = pad_out_ff;
  assign pad_oe_out = pad_oe_ff;
  assign sel_rd_val_out = sel_rd_ff;
  assign host_spi_out = host_spi_ff;
  assign host_ready_out = host_ready;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_sel_write_lands: assert property (sel_ok |=>
    sel_ff[$past(sel_idx_in)] == $past(sel_val_in))
    else $error("select write lost");
  a_sel_reset_zero: assert property (first_ff |-> sel_ff == '0)
    else $error("select not gpio after reset");
  a_strap_held: assert property (host_ready |=> host_ready && $stable(host_spi_ff))
    else $error("host port changed after capture");
  a_wake_uart_tx: assert property (u[PIN_WAKE] |=>
    pad_oe_out[PIN_WAKE] && pad_out_out[PIN_WAKE] == $past(uart_txd_in))
    else $error("wake pin not driving uart transmit");
  a_irq_request: assert property (p[PIN_IRQ] |=>
    pad_oe_out[PIN_IRQ] && pad_out_out[PIN_IRQ] == $past(interrupt_request_n_in))
    else $error("interrupt pin not driving request");
  a_spi_mosi_path: assert property (hs ##1 hs ##1 hs |->
    spi_mosi_out == $past(pad_in_in[PIN_DAT2], 3))
    else $error("mosi not taken from data2 pad");
  a_spi_ready_time: assert property (first_ff |-> ##3 host_ready)
    else $error("host port not ready three cycles after reset");
  a_miso_select: assert property (pad_oe_out[PIN_DAT0] && host_spi_ff |->
    $past(ps[PIN_DAT1]) == 1'b0)
    else $error("miso driven while select high");
  a_unassigned_off: assert property (sel_ff[PIN_WAKE] == 3'h5 |=>
    !pad_oe_out[PIN_WAKE])
    else $error("unassigned select drives pad");
  a_rxd_idle: assert property ((u[PIN_IRQ] | u[PIN_CCLK] | u[PIN_SCLK]) == 1'b0 |=>
    uart_rxd_out) else $error("uart receive not idle");

  c_spi_mode: cover property (host_ready && host_spi_ff);
  c_card_mode: cover property (host_ready && !host_spi_ff);
  c_rxd_two_pins: cover property (u[PIN_IRQ] && u[PIN_SCLK]);

endmodule

// file: epm_pkg.sv
// shared constants for the external interface pin multiplexer
package epm_pkg;

  // ----------------------------------------------------------------
  // select field
  // ----------------------------------------------------------------
  localparam int EPM_SEL_W = 3;
  localparam logic [2:0] EPM_SEL_RESET = 3'h0;
  localparam logic [2:0] EPM_SEL_GPIO = 3'h0;
  localparam logic [2:0] EPM_SEL_PRI = 3'h1;
  localparam logic [2:0] EPM_SEL_ALT = 3'h2;
  localparam logic [2:0] EPM_SEL_UART = 3'h3;
  localparam logic [2:0] EPM_SEL_MST = 3'h4;
  localparam logic [2:0] EPM_SEL_COEX = 3'h6;
  localparam logic [2:0] EPM_SEL_MAX = 3'h6;

  // ----------------------------------------------------------------
  // pad indices
  // ----------------------------------------------------------------
  localparam int EPM_NUM_PINS = 14;
  localparam int EPM_IDX_W = 4;
  localparam int PIN_WAKE = 0;
  localparam int PIN_IRQ = 1;
  localparam int PIN_DAT3 = 2;
  localparam int PIN_DAT2 = 3;
  localparam int PIN_DAT1 = 4;
  localparam int PIN_DAT0 = 5;
  localparam int PIN_CMD = 6;
  localparam int PIN_CCLK = 7;
  localparam int PIN_SCLK = 8;
  localparam int PIN_G15 = 9;
  localparam int PIN_G16 = 10;
  localparam int PIN_G18 = 11;
  localparam int PIN_TWC = 12;
  localparam int PIN_TWD = 13;

  // ----------------------------------------------------------------
  // peripheral widths and strap level
  // ----------------------------------------------------------------
  localparam int EPM_GPIO_W = 19;
  localparam int EPM_COEX_W = 7;
  localparam logic EPM_STRAP_SPI = 1'b1;

  // strap capture sequence, gray coded
  typedef enum logic [1:0]
  {
    EPM_ST_FILL1 = 2'b00,
    EPM_ST_FILL2 = 2'b01,
    EPM_ST_SAMPLE = 2'b11,
    EPM_ST_HELD = 2'b10
  } epm_strap_e;

endpackage

// file: epm_sync.sv
// two flip-flop synchroniser for pad inputs
`timescale 1ns/1ps
module epm_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// file: tb_top.sv
// self-checking testbench for the pin multiplexer
`timescale 1ns/1ps
module tb_top
  import epm_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap_hi = 1'b1;
  logic [13:0] ext_en = '0;
  logic [13:0] ext_val = '0;
  logic [13:0] pad_lvl, pad_out, pad_oe;
  logic strap;
  logic sel_wr = 1'b0;
  logic [3:0] sel_idx = '0;
  logic [3:0] rd_idx = '0;
  logic [2:0] sel_val = '0;
  logic [2:0] rd_val;
  logic host_spi, host_ready, wake_in, rxd, bm_clk, bm_dat, bs_clk, bs_dat;
  logic [18:0] gpio_out = 19'h00187;
  logic [18:0] gpio_oe = 19'h00187;
  logic [18:0] gpio_in;
  logic irq_n = 1'b0;
  logic txd = 1'b0;
  logic od_drv = 1'b1;
  logic [6:0] coex_out = 7'h7F;
  logic [6:0] coex_oe = 7'h7F;
  logic [6:0] coex_line;
  logic [3:0] cd_out = '0;
  logic [3:0] cd_oe = '0;
  logic [3:0] cd_line;
  logic cmd_out = 1'b0;
  logic cmd_oe = 1'b0;
  logic cmd_line, card_clk, slow_clk, miso, miso_oe, mosi, cs_n, sck;
  int num_errors = 0;
  int checks = 0;
  int pins [7] = '{PIN_WAKE, PIN_IRQ, PIN_DAT3, PIN_CCLK, PIN_SCLK, PIN_TWC, PIN_TWD};
  // expected {oe, out} per pin and select 0..6
  logic [1:0] tab [7][7] = '{'{3, 0, 0, 2, 2, 0, 3}, '{3, 2, 0, 0, 0, 0, 3},
    '{3, 0, 0, 2, 0, 0, 3}, '{3, 0, 0, 0, 0, 0, 3}, '{3, 0, 0, 0, 2, 0, 3},
    '{0, 2, 0, 0, 2, 0, 3}, '{0, 2, 0, 0, 2, 0, 3}};

  // ----------------------------------------------------------------
  // clock, board and design
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;
  epm_board_model i_epm_board_model (.ref_clk_in(clk), .strap_hi_in(strap_hi),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_out_in(pad_out), .pad_oe_in(pad_oe),
    .strap_out(strap), .pad_level_out(pad_lvl));
  epm_pin_mux i_epm_pin_mux (.ref_clk_in(clk), .arst_n_in(rst_n), .pad_in_in(pad_lvl),
    .host_cfg_strap_in(strap), .pad_out_out(pad_out), .pad_oe_out(pad_oe),
    .sel_wr_in(sel_wr), .sel_idx_in(sel_idx), .sel_val_in(sel_val),
    .sel_rd_idx_in(rd_idx), .sel_rd_val_out(rd_val), .host_spi_out(host_spi),
    .host_ready_out(host_ready), .gpio_out_in(gpio_out), .gpio_oe_in(gpio_oe),
    .gpio_in_out(gpio_in), .host_wake_input_out(wake_in), .interrupt_request_n_in(irq_n),
    .uart_txd_in(txd), .uart_rxd_out(rxd), .bus_master_clock_drive_in(od_drv),
    .bus_master_clock_line_out(bm_clk), .bus_master_data_drive_in(od_drv),
    .bus_master_data_line_out(bm_dat), .bus_slave_clock_drive_in(od_drv),
    .bus_slave_clock_line_out(bs_clk), .bus_slave_data_drive_in(od_drv),
    .bus_slave_data_line_out(bs_dat), .coexistence_signal_out_in(coex_out),
    .coexistence_signal_oe_in(coex_oe), .coexistence_signal_line_out(coex_line),
    .card_data_out_in(cd_out), .card_data_oe_in(cd_oe), .card_data_line_out(cd_line),
    .card_command_out_in(cmd_out), .card_command_oe_in(cmd_oe),
    .card_command_line_out(cmd_line), .card_clock_input_out(card_clk),
    .slow_clock_out(slow_clk), .spi_miso_in(miso), .spi_miso_oe_in(miso_oe),
    .spi_mosi_out(mosi), .chip_select_n_out(cs_n), .spi_sck_out(sck));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // reset with the strap at the given level, then let the strap capture land
  task automatic do_reset(input logic hi);
    @(negedge clk);
    strap_hi = hi;
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic wr(input int idx, input int val);
    @(negedge clk);
    sel_wr = 1'b1;
    sel_idx = 4'(idx);
    sel_val = 3'(val);
    @(negedge clk);
    sel_wr = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic rd(input int idx, input int exp);
    @(negedge clk);
    rd_idx = 4'(idx);
    @(negedge clk);
    chk("select readback", rd_val, exp);
  endtask

  task automatic pad(input int idx, input logic val);
    @(negedge clk);
    ext_en[idx] = 1'b1;
    ext_val[idx] = val;
    repeat (4) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial
  begin
    miso = 1'b1;
    miso_oe = 1'b1;
    do_reset(1'b1);
    chk("host ready", host_ready, 1);
    chk("spi port", host_spi, 1);
    // gpio-mode pads follow the gpio enables; the slave-out pad follows a floating select
    chk("pad enables", pad_oe & 14'h3FDF, 14'h0187);
    for (int i = 0; i < 14; i++)
      rd(i, 0);
    for (int v = 0; v < 8; v++)
    begin
      wr(PIN_G15, v);
      rd(PIN_G15, v < 7 ? v : 6);
    end
    wr(14, 3);
    rd(14, 0);
    for (int p = 0; p < 7; p++)
    begin
      for (int s = 0; s < 7; s++)
      begin
        wr(pins[p], s);
        chk("pad drive", {pad_oe[pins[p]], pad_oe[pins[p]] & pad_out[pins[p]]},
          tab[p][s]);
      end
      wr(pins[p], 0);
    end
    wr(PIN_IRQ, 3);
    wr(PIN_CCLK, 3);
    pad(PIN_IRQ, 1'b0);
    pad(PIN_CCLK, 1'b1);
    chk("uart rx", rxd, 0);
    wr(PIN_IRQ, 0);
    chk("uart rx", rxd, 1);
    pad(PIN_CCLK, 1'b0);
    chk("uart rx", rxd, 0);
    wr(PIN_CCLK, 0);
    chk("uart rx", rxd, 1);
    wr(PIN_WAKE, 1);
    pad(PIN_WAKE, 1'b1);
    chk("wake input", wake_in, 1);
    wr(PIN_TWC, 3);
    pad(PIN_TWC, 1'b1);
    chk("slow clock", slow_clk, 1);
    wr(PIN_TWD, 1);
    pad(PIN_TWD, 1'b0);
    chk("slave data", bs_dat, 0);
    wr(PIN_SCLK, 6);
    chk("coex line", coex_line, 7'h10);
    // open-drain functions released, so the board alone sets the line
    od_drv = 1'b0;
    wr(PIN_SCLK, 4);
    pad(PIN_SCLK, 1'b0);
    chk("master data", bm_dat, 0);
    chk("master data release", pad_oe[PIN_SCLK], 0);
    wr(PIN_TWC, 4);
    pad(PIN_TWC, 1'b0);
    chk("master clock", bm_clk, 0);
    wr(PIN_TWC, 1);
    chk("slave clock", bs_clk, 0);
    wr(PIN_CCLK, 1);
    pad(PIN_CCLK, 1'b1);
    chk("card clock", card_clk, 1);
    chk("gpio in", gpio_in[8:7], 1);
    pad(PIN_DAT2, 1'b1);
    pad(PIN_CMD, 1'b1);
    pad(PIN_DAT1, 1'b0);
    chk("spi rx", mosi, 1);
    chk("spi clock", sck, 1);
    chk("spi select", cs_n, 0);
    chk("spi tx", {pad_oe[PIN_DAT0], pad_out[PIN_DAT0]}, 3);
    pad(PIN_DAT1, 1'b1);
    chk("spi tx idle", pad_oe[PIN_DAT0], 0);
    do_reset(1'b0);
    chk("spi port", host_spi, 0);
    rd(PIN_G15, 0);
    wr(PIN_DAT2, 2);
    pad(PIN_DAT2, 1'b0);
    pad(PIN_CMD, 1'b0);
    chk("card data", cd_line[3:1], 3'h5);
    chk("card cmd", cmd_line, 0);
    cd_oe = 4'h1;
    repeat (3) @(negedge clk);
    chk("card data0", {pad_oe[PIN_DAT0], pad_out[PIN_DAT0]}, 2);
    end_sim();
  end
endmodule
